// ==== rtl/tcs_mode_select.sv ====
// Top of the Type-C strap and mode select logic.
// Assumes pins are asynchronous and pass two flops; CC detection comes from the CC engine.
//
// The strobed register port and the address map were left to the implementer.
`timescale 1ns/1ns
`default_nettype none
module tcs_mode_select (
  input  wire logic       CORE_CLK,
  input  wire logic       RST,
  input  wire logic [1:0] PORT_STRAP,          // Tri-level port-role strap
  input  wire logic [1:0] CURRENT_STRAP,       // Tri-level current strap
  input  wire logic [1:0] ADDR_STRAP,          // Tri-level address strap
  input  wire logic       SUPPLY_GOOD,         // Main supply present
  input  wire logic       CC_LOGIC_ENABLE_N,   // CC controller enable, low active
  input  wire logic       SS_SWITCH_ENABLE_N,  // Mux enable, low active
  input  wire logic       BUS_POWER_SENSE,     // Bus voltage present
  input  wire logic       CC_ATTACHED,         // CC engine sees a partner
  input  wire logic       CC_ACTING_SOURCE,    // Dual role currently source
  input  wire logic       CC2_ACTIVE,          // Second CC line carries the link
  input  wire logic [3:0] REG_ADDR,
  input  wire logic [7:0] REG_WDATA,
  input  wire logic       REG_WR,
  input  wire logic       REG_RD,
  output logic      [7:0] REG_RDATA,
  output logic      [1:0] ROLE,                // Held role
  output logic      [1:0] ADV_CURRENT,         // Advertised current code
  output logic            PIN_MODE,            // Serial control disabled
  output logic      [6:0] SERIAL_ADDR,         // Serial address
  output logic            SS_SWITCH_ON,        // Mux running
  output logic            SINK_ATTACHED,       // Sink attach confirmed
  output logic            ORIENT_OUT,          // Open-drain pin level (low when driven)
  output logic            ORIENT_OE,           // High while pulling low
  output logic            SOURCE_ATTACH_OUT_N, // Attach pin level
  output logic            SOURCE_ATTACH_OE     // High while pulling low
);

  ////////////////////////////////////////////////////////////////////////////
  // Two-flop synchronisers for every pin except the register port
  localparam int SYNC_W = 13;
  logic [SYNC_W-1:0] pins_in;     // Raw pins
  logic [SYNC_W-1:0] sync1_r;     // First stage, read only by second
  logic [SYNC_W-1:0] sync2_r;     // Usable stage

  assign pins_in = {PORT_STRAP, CURRENT_STRAP, ADDR_STRAP, SUPPLY_GOOD,
                    CC_LOGIC_ENABLE_N, SS_SWITCH_ENABLE_N, BUS_POWER_SENSE,
                    CC_ATTACHED, CC_ACTING_SOURCE, CC2_ACTIVE};

  // Shift both stages together
  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      // Both stages reset to the idle pin levels, so no false edge or mux blip
      sync1_r <= {{6{1'b0}}, 1'b0, 1'b1, 1'b1, 4'h0};
      sync2_r <= {{6{1'b0}}, 1'b0, 1'b1, 1'b1, 4'h0};
    end else begin
      sync1_r <= pins_in;
      sync2_r <= sync1_r;
    end
  end

  // Named views of the synchronised pins
  wire logic [1:0] port_s     = sync2_r[12:11];
  wire logic [1:0] cur_s      = sync2_r[10:9];
  wire logic [1:0] addr_s     = sync2_r[8:7];
  wire logic       supply_s   = sync2_r[6];
  wire logic       cc_en_n_s  = sync2_r[5];
  wire logic       mux_en_n_s = sync2_r[4];
  wire logic       vbus_s     = sync2_r[3];
  wire logic       attach_s   = sync2_r[2];
  wire logic       act_src_s  = sync2_r[1];
  wire logic       cc2_s      = sync2_r[0];

  ////////////////////////////////////////////////////////////////////////////
  // Sampling events
  logic cc_en_n_r;     // Previous enable level
  logic srst_r;        // Soft reset pulse from the register port
  logic cc_enabled;    // CC logic running

  // Host holds enable low to run the CC logic
  assign cc_enabled = ~cc_en_n_s & supply_s;

  wire logic enable_fall = cc_en_n_r & ~cc_en_n_s & supply_s;
  wire logic soft_reset  = srst_r;
  wire logic ctrl_hit    = REG_WR & (REG_ADDR == tcs_pkg::OFS_CTRL);

  // Remember enable and turn a write into a one-cycle pulse
  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      cc_en_n_r <= 1'b1;
      srst_r    <= 1'b0;
    end else begin
      cc_en_n_r <= cc_en_n_s;
      srst_r    <= ctrl_hit & REG_WDATA[tcs_pkg::CTRL_SRST_BIT];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Strap sampler
  tcs_strap_if st ();

  assign st.sample   = enable_fall | soft_reset;
  assign st.port_lvl = tcs_pkg::tcs_level_type'(port_s);
  assign st.cur_lvl  = tcs_pkg::tcs_level_type'(cur_s);
  assign st.addr_lvl = tcs_pkg::tcs_level_type'(addr_s);

  tcs_sampler u_sampler (
    .CORE_CLK (CORE_CLK),
    .RST      (RST),
    .st       (st.sampler)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Derived behaviour
  wire logic is_sink   = (st.role == tcs_pkg::TCS_ROLE_SINK);
  wire logic is_source = (st.role == tcs_pkg::TCS_ROLE_SOURCE);
  wire logic as_source = is_source | ((st.role == tcs_pkg::TCS_ROLE_DUAL) & act_src_s);

  // Strap only counts in pin mode as source or dual role; sink never looks at it
  wire logic [1:0] adv_nxt = (is_sink | ~st.pin_mode) ? tcs_pkg::CUR_DEFAULT :
                             st.current;
  // Sink attach needs bus voltage; dual role acting as sink too
  wire logic sink_att_nxt = cc_enabled & attach_s & ~as_source & vbus_s;
  wire logic src_att_nxt  = cc_enabled & attach_s & as_source;
  // Pull low on CC2, release on CC1 or idle
  wire logic orient_nxt   = cc_enabled & attach_s & cc2_s;
  wire logic mux_on_nxt   = ~mux_en_n_s;

  // Status byte for the register port
  wire logic [7:0] rd_nxt = ~REG_RD ? 8'h00 :
                            (REG_ADDR == tcs_pkg::OFS_STATUS) ?
                              {st.role, adv_nxt, st.pin_mode, mux_on_nxt,
                               src_att_nxt, sink_att_nxt} :
                            8'h00;

  ////////////////////////////////////////////////////////////////////////////
  // Output flops
  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      REG_RDATA           <= 8'h00;
      ROLE                <= tcs_pkg::RST_ROLE;
      ADV_CURRENT         <= tcs_pkg::RST_CURRENT;
      PIN_MODE            <= 1'b1;
      SERIAL_ADDR         <= tcs_pkg::ADDR_NONE;
      SS_SWITCH_ON        <= 1'b0;
      SINK_ATTACHED       <= 1'b0;
      ORIENT_OE           <= 1'b0;
      SOURCE_ATTACH_OE    <= 1'b0;
    end else begin
      REG_RDATA           <= rd_nxt;
      ROLE                <= st.role;
      ADV_CURRENT         <= adv_nxt;
      PIN_MODE            <= st.pin_mode;
      SERIAL_ADDR         <= st.addr;
      SS_SWITCH_ON        <= mux_on_nxt;
      SINK_ATTACHED       <= sink_att_nxt;
      ORIENT_OE           <= orient_nxt;
      SOURCE_ATTACH_OE    <= src_att_nxt;
    end
  end

  // Open-drain data pins only ever drive low
  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      ORIENT_OUT          <= 1'b0;
      SOURCE_ATTACH_OUT_N <= 1'b0;
    end else begin
      ORIENT_OUT          <= 1'b0;
      SOURCE_ATTACH_OUT_N <= 1'b0;
    end
  end

endmodule
`default_nettype wire

// ==== inc/tcs_pkg.sv ====
// Package for the Type-C strap and mode select block.
// Assumes a single 100 MHz core clock; tri-level pins arrive pre-digitised as two bits.
package tcs_pkg;

  // Tri-level pin encoding after the analog comparators
  typedef enum logic [1:0] {
    TCS_LVL_LOW,
    TCS_LVL_MID,
    TCS_LVL_HIGH
  } tcs_level_type;

  // Port role held after sampling
  typedef enum logic [1:0] {
    TCS_ROLE_SINK,
    TCS_ROLE_DUAL,
    TCS_ROLE_SOURCE
  } tcs_role_type;

  // Advertised current encoding
  localparam logic [1:0] CUR_DEFAULT  = 2'h0;  // 900 mA
  localparam logic [1:0] CUR_MEDIUM   = 2'h1;  // 1.5 A
  localparam logic [1:0] CUR_HIGH     = 2'h2;  // 3 A

  // Serial control addresses
  localparam logic [6:0] ADDR_HIGH    = 7'h67;
  localparam logic [6:0] ADDR_LOW     = 7'h47;
  localparam logic [6:0] ADDR_NONE    = 7'h00;

  // Register map of the plain register port
  localparam logic [3:0] OFS_CTRL     = 4'h0;  // bit0 soft reset (self clearing)
  localparam logic [3:0] OFS_STATUS   = 4'h4;  // held configuration and state
  localparam int         CTRL_SRST_BIT = 0;

  // Reset values
  localparam logic [1:0] RST_ROLE     = 2'h1;  // dual role until first sample
  localparam logic [1:0] RST_CURRENT  = 2'h0;

endpackage

// ==== inc/tcs_strap_if.sv ====
// Interface carrying the sampled strap set between sampler and top.
// Assumes both ends share CORE_CLK.
`timescale 1ns/1ns
`default_nettype none
interface tcs_strap_if;
  logic                     sample;     // One-cycle capture request
  tcs_pkg::tcs_level_type   port_lvl;   // Synchronised port-role strap
  tcs_pkg::tcs_level_type   cur_lvl;    // Synchronised current strap
  tcs_pkg::tcs_level_type   addr_lvl;   // Synchronised address strap
  tcs_pkg::tcs_role_type    role;       // Held role
  logic [1:0]               current;    // Held current code
  logic                     pin_mode;   // Held: serial control disabled
  logic [6:0]               addr;       // Held serial address

  modport sampler (input sample, input port_lvl, input cur_lvl, input addr_lvl,
                   output role, output current, output pin_mode, output addr);
  modport user    (output sample, output port_lvl, output cur_lvl, output addr_lvl,
                   input role, input current, input pin_mode, input addr);
endinterface
`default_nettype wire

// ==== rtl/tcs_sampler.sv ====
// Strap sampler: decodes and holds the three tri-level straps.
// Assumes strap levels are already synchronised by the caller.
`timescale 1ns/1ns
`default_nettype none
module tcs_sampler (
  input  wire logic      CORE_CLK,
  input  wire logic      RST,
  tcs_strap_if.sampler   st
);

  ////////////////////////////////////////////////////////////////////////////
  // Decode
  tcs_pkg::tcs_role_type role_nxt;      // Role from port strap
  logic [1:0]            current_nxt;   // Current from current strap
  logic                  pin_mode_nxt;  // Address strap open
  logic [6:0]            addr_nxt;      // Serial address

  // High source, open dual, low sink
  assign role_nxt = (st.port_lvl == tcs_pkg::TCS_LVL_HIGH) ? tcs_pkg::TCS_ROLE_SOURCE :
                    (st.port_lvl == tcs_pkg::TCS_LVL_MID)  ? tcs_pkg::TCS_ROLE_DUAL :
                                                             tcs_pkg::TCS_ROLE_SINK;
  // Low default, middle medium, high high
  assign current_nxt = (st.cur_lvl == tcs_pkg::TCS_LVL_HIGH) ? tcs_pkg::CUR_HIGH :
                       (st.cur_lvl == tcs_pkg::TCS_LVL_MID)  ? tcs_pkg::CUR_MEDIUM :
                                                               tcs_pkg::CUR_DEFAULT;
  assign pin_mode_nxt = (st.addr_lvl == tcs_pkg::TCS_LVL_MID);
  assign addr_nxt = (st.addr_lvl == tcs_pkg::TCS_LVL_HIGH) ? tcs_pkg::ADDR_HIGH :
                    (st.addr_lvl == tcs_pkg::TCS_LVL_LOW)  ? tcs_pkg::ADDR_LOW :
                                                             tcs_pkg::ADDR_NONE;

  ////////////////////////////////////////////////////////////////////////////
  // Hold between sampling events so strap wiggles do nothing
  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      st.role     <= tcs_pkg::TCS_ROLE_DUAL;
      st.current  <= tcs_pkg::RST_CURRENT;
      st.pin_mode <= 1'b1;
      st.addr     <= tcs_pkg::ADDR_NONE;
    end else if (st.sample) begin
      st.role     <= role_nxt;
      st.current  <= current_nxt;
      st.pin_mode <= pin_mode_nxt;
      st.addr     <= addr_nxt;
    end
  end

endmodule
`default_nettype wire

// ==== testbench/tcs_mode_select_properties.sv ====
// Port checker for the strap and mode select top.
// Assumes a bind from the bench top; one clock, RST async high.
`timescale 1ns/1ns
`default_nettype none
module tcs_mode_select_properties (
  input wire logic       CORE_CLK,
  input wire logic       RST,
  input wire logic [1:0] PORT_STRAP,
  input wire logic [1:0] CURRENT_STRAP,
  input wire logic [1:0] ADDR_STRAP,
  input wire logic       SUPPLY_GOOD,
  input wire logic       CC_LOGIC_ENABLE_N,
  input wire logic       SS_SWITCH_ENABLE_N,
  input wire logic       BUS_POWER_SENSE,
  input wire logic       CC_ATTACHED,
  input wire logic       CC_ACTING_SOURCE,
  input wire logic       CC2_ACTIVE,
  input wire logic       REG_WR,
  input wire logic [3:0] REG_ADDR,
  input wire logic [7:0] REG_WDATA,
  input wire logic [1:0] ROLE,
  input wire logic [1:0] ADV_CURRENT,
  input wire logic       PIN_MODE,
  input wire logic [6:0] SERIAL_ADDR,
  input wire logic       SS_SWITCH_ON,
  input wire logic       SINK_ATTACHED,
  input wire logic       ORIENT_OE
);
  default clocking @(posedge CORE_CLK); endclocking
  default disable iff (RST);
  logic [2:0] quiet_r; // Cycles since a capture cause
  // Saturates; enable high, supply loss or any write restarts it
  always_ff @(posedge CORE_CLK or posedge RST)
    if (RST) quiet_r <= 3'h0;
    else if (CC_LOGIC_ENABLE_N || REG_WR || !SUPPLY_GOOD) quiet_r <= 3'h0;
    else if (quiet_r != 3'h7) quiet_r <= quiet_r + 3'h1;
  function automatic logic [1:0] role_of(logic [1:0] l);
    return (l == 2'h2) ? 2'h2 : (l == 2'h1) ? 2'h1 : 2'h0;
  endfunction
  //////////////////////////////////////////////////////////
  // Enable fall with supply up, straps still; covers sync delay
  sequence cap_s;
    (CC_LOGIC_ENABLE_N && SUPPLY_GOOD)[*3] ##1 (!CC_LOGIC_ENABLE_N && SUPPLY_GOOD
      && $stable({PORT_STRAP, CURRENT_STRAP, ADDR_STRAP}))[*6];
  endsequence
  sequence srst_s;
    REG_WR && REG_ADDR == tcs_pkg::OFS_CTRL && REG_WDATA[0] && $stable(PORT_STRAP)
      ##1 $stable(PORT_STRAP)[*4];
  endsequence
  role_decode_a: assert property (cap_s |-> ROLE == role_of(PORT_STRAP))
    else $error("role differs from strap");
  addr_decode_a: assert property (cap_s |-> PIN_MODE == (ADDR_STRAP == 2'h1)
    && SERIAL_ADDR == ((ADDR_STRAP == 2'h2) ? tcs_pkg::ADDR_HIGH : (ADDR_STRAP == 2'h1)
    ? tcs_pkg::ADDR_NONE : tcs_pkg::ADDR_LOW)) else $error("address decode wrong");
  cur_decode_a: assert property (cap_s |-> ADV_CURRENT == ((ROLE == 2'h2 && PIN_MODE)
    ? CURRENT_STRAP : (ROLE == 2'h1 && PIN_MODE) ? CURRENT_STRAP : tcs_pkg::CUR_DEFAULT))
    else $error("advertised current wrong");
  soft_reset_a: assert property (srst_s |-> ROLE == role_of(PORT_STRAP))
    else $error("soft reset did not resample");
  straps_held_a: assert property (quiet_r == 3'h7 |-> $stable({ROLE, PIN_MODE, SERIAL_ADDR}))
    else $error("held straps moved");
  mux_on_a: assert property ($stable(SS_SWITCH_ENABLE_N)[*5]
    |-> SS_SWITCH_ON == !SS_SWITCH_ENABLE_N) else $error("mux state wrong");
  orient_oe_a: assert property ($stable({CC_ATTACHED, CC2_ACTIVE})[*5]
    |-> ORIENT_OE == (CC_ATTACHED && CC2_ACTIVE)) else $error("orientation wrong");
  sink_attach_a: assert property (($stable({BUS_POWER_SENSE, CC_ACTING_SOURCE, ROLE})
    && CC_ATTACHED)[*5] |-> SINK_ATTACHED == (BUS_POWER_SENSE && (ROLE == 2'h0
    || ROLE == 2'h1 && !CC_ACTING_SOURCE))) else $error("sink attach wrong");
endmodule
`default_nettype wire

// ==== testbench/tcs_partner_model.sv ====
// Far-side partner: plug, orientation, partner role, bus power.
// Assumes the bench commands it; bus power rises LAG cycles late.
`timescale 1ns/1ns
`default_nettype none
module tcs_partner_model #(
  parameter int LAG = 3 // Slow ramp of bus power
) (
  input  wire logic clk,
  input  wire logic plug_in,             // Cable seated
  input  wire logic flipped,             // Plug turned over
  input  wire logic sinks,               // Far side sinks, we source
  input  wire logic feeds,               // Far side feeds bus power
  output logic      attached = 1'h0,
  output logic      cc2_active = 1'h0,
  output logic      acting_source = 1'h0,
  output logic      bus_power = 1'h0     // Pulled down when unfed
);
  int lag_r = 0; // Ramp counter
  // Unplugged, every line drops to its pulled-down level
  always @(posedge clk) begin
    attached <= plug_in;
    cc2_active <= plug_in && flipped;
    acting_source <= plug_in && sinks;
    lag_r <= (plug_in && feeds) ? lag_r + 1 : 0;
    bus_power <= lag_r >= LAG;
  end
endmodule
`default_nettype wire

// ==== testbench/tcs_mode_select_tb.sv ====
// Bench: strap captures, soft reset, mux, attach and status.
// Assumes package, interface, design and partner compiled first.
`timescale 1ns/1ns
`default_nettype none
module tcs_mode_select_tb;
  logic       clk = 1'h0, rst = 1'h1, supply = 1'h1, en_n = 1'h1, ss_en_n = 1'h1;
  logic       plug = 1'h0, flip = 1'h0, psink = 1'h0, pfeed = 1'h0, wr = 1'h0, rd = 1'h0;
  logic [1:0] port_s = 2'h0, cur_s = 2'h0, addr_s = 2'h0, role, adv;
  logic [3:0] ra = 4'h0;
  logic [7:0] wd = 8'h00, rdata;
  logic [6:0] saddr;
  logic       pmode, sw_on, snk, o_oe, s_oe, att, cc2, asrc, vbus, o_out, s_out;
  int         n_errors = 0, n_compared = 0, cyc = 0;
  always #5 clk = ~clk;
  tcs_mode_select u_dut (.CORE_CLK(clk), .RST(rst), .PORT_STRAP(port_s),
    .CURRENT_STRAP(cur_s), .ADDR_STRAP(addr_s), .SUPPLY_GOOD(supply),
    .CC_LOGIC_ENABLE_N(en_n), .SS_SWITCH_ENABLE_N(ss_en_n), .BUS_POWER_SENSE(vbus),
    .CC_ATTACHED(att), .CC_ACTING_SOURCE(asrc), .CC2_ACTIVE(cc2), .REG_ADDR(ra),
    .REG_WDATA(wd), .REG_WR(wr), .REG_RD(rd), .REG_RDATA(rdata), .ROLE(role),
    .ADV_CURRENT(adv), .PIN_MODE(pmode), .SERIAL_ADDR(saddr), .SS_SWITCH_ON(sw_on),
    .SINK_ATTACHED(snk), .ORIENT_OUT(o_out), .ORIENT_OE(o_oe), .SOURCE_ATTACH_OUT_N(s_out),
    .SOURCE_ATTACH_OE(s_oe));
  tcs_partner_model u_partner (.clk(clk), .plug_in(plug), .flipped(flip), .sinks(psink),
    .feeds(pfeed), .attached(att), .cc2_active(cc2), .acting_source(asrc), .bus_power(vbus));
  //////////////////////////////////////////////////////////
  task automatic report_and_stop;
    $display("compared %0d mismatches %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_errors++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic wait_n(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic reg_wr(input logic [3:0] a, input logic [7:0] d);
    ra <= a;
    wd <= d;
    wr <= 1'h1;
    @(posedge clk);
    wr <= 1'h0;
    @(posedge clk);
  endtask
  // Read data stands only in the cycle after the strobe
  task automatic reg_rd(input logic [3:0] a, input logic [7:0] exp);
    ra <= a;
    rd <= 1'h1;
    @(posedge clk);
    rd <= 1'h0;
    #1;
    chk(rdata, exp);
    @(posedge clk);
  endtask
  // Host enables the CC logic by a falling enable
  task automatic cap(input int p, input int c, input int a);
    port_s <= 2'(p);
    cur_s <= 2'(c);
    addr_s <= 2'(a);
    en_n <= 1'h1;
    wait_n(4);
    en_n <= 1'h0;
    wait_n(8);
  endtask
  function automatic logic [1:0] exp_role(input logic [1:0] l);
    return (l == 2'h2) ? 2'h2 : (l == 2'h1) ? 2'h1 : 2'h0;
  endfunction
  // Hang guard, well beyond the few hundred cycles needed
  always @(posedge clk) begin
    cyc++;
    if (cyc == 4000) begin
      n_errors++;
      report_and_stop();
    end
  end
  initial begin
    wait_n(4);
    rst <= 1'h0;
    @(posedge clk);
    chk(role, tcs_pkg::RST_ROLE);
    for (int i = 0; i < 27; i++) begin
      cap(i % 3, (i / 3) % 3, i / 9);
      chk(role, exp_role(port_s));
      chk(pmode, addr_s == 2'h1);
      chk(saddr, (addr_s == 2'h2) ? 7'h67 : (addr_s == 2'h1) ? 7'h00 : 7'h47);
      if (port_s != 2'h1) chk(adv, (port_s == 2'h2 && addr_s == 2'h1) ? cur_s : 2'h0);
    end
    $display("capture table done");
    port_s <= 2'h0;
    wait_n(8);
    chk(role, 2'h2);
    supply <= 1'h0;
    cap(1, 2, 2);
    chk(role, 2'h2);
    supply <= 1'h1;
    cap(2, 2, 2);
    port_s <= 2'h0;
    reg_wr(tcs_pkg::OFS_CTRL, 8'h00);
    reg_wr(4'h8, 8'h01);
    wait_n(6);
    chk(role, 2'h2);
    reg_wr(tcs_pkg::OFS_CTRL, 8'h01);
    wait_n(6);
    chk(role, 2'h0);
    reg_rd(4'h8, 8'h00);
    $display("soft reset done");
    for (int j = 1; j >= 0; j--) begin
      ss_en_n <= 1'(j);
      wait_n(5);
      chk(sw_on, j == 0);
    end
    for (int p = 0; p < 3; p++) begin
      cap(p, 2, 1);
      for (int f = 0; f < 2; f++) begin
        plug <= 1'h1;
        flip <= 1'(f);
        psink <= p != 0;
        pfeed <= p == 0;
        wait_n(10);
        chk(o_oe, f);
        chk(s_oe, p != 0);
        chk(snk, p == 0);
        chk({o_out, s_out}, 2'h0);
        if (p != 1) reg_rd(tcs_pkg::OFS_STATUS, {exp_role(2'(p)), (p == 2) ? 2'h2 : 2'h0, 2'h3, p == 2, p == 0});
        plug <= 1'h0;
        wait_n(6);
      end
    end
    $display("attach done");
    report_and_stop();
  end
endmodule
bind tcs_mode_select tcs_mode_select_properties u_props (.CORE_CLK, .RST, .PORT_STRAP,
  .CURRENT_STRAP, .ADDR_STRAP, .SUPPLY_GOOD, .CC_LOGIC_ENABLE_N, .SS_SWITCH_ENABLE_N,
  .BUS_POWER_SENSE, .CC_ATTACHED, .CC_ACTING_SOURCE, .CC2_ACTIVE, .REG_WR, .REG_ADDR,
  .REG_WDATA, .ROLE, .ADV_CURRENT, .PIN_MODE, .SERIAL_ADDR, .SS_SWITCH_ON, .SINK_ATTACHED,
  .ORIENT_OE);
`default_nettype wire
